//--- pkg/asenv_regs.vh
// Constants for the wide-mode register environment and address model.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef ASENV_REGS_VH
`define ASENV_REGS_VH
// =====================================================================
// Register file shape
`define ASENV_GPR_COUNT 16
`define ASENV_GPR_IDX_W 4
`define ASENV_XLEN 64
`define ASENV_VEC_COUNT 16
`define ASENV_VEC_W 128
`define ASENV_CTRL_COUNT 16
`define ASENV_DBG_COUNT 8
`define ASENV_TABLE_LIMIT_W 16
`define ASENV_FLAGS_LEGACY_W 32
// =====================================================================
// Address widths
`define ASENV_LIN_W 48
`define ASENV_PHYS_W 40
`define ASENV_LEGACY_PHYS_W 36
`define ASENV_REAL_W 20
`define ASENV_SEG_OFS_W 16
`define ASENV_SEL_INDEX_MAX 14'h3fff
`define ASENV_PAGE_SHIFT 12
`define ASENV_LARGE_PAGE_SHIFT 22
// =====================================================================
// Access size codes
`define ASENV_SZ_BYTE 2'h0
`define ASENV_SZ_WORD 2'h1
`define ASENV_SZ_DWORD 2'h2
`define ASENV_SZ_QWORD 2'h3
// =====================================================================
// Memory model codes
`define ASENV_MODEL_FLAT 2'h0
`define ASENV_MODEL_SEG 2'h1
`define ASENV_MODEL_REAL 2'h2
`define ASENV_MODEL_WIDE 2'h3
// =====================================================================
// Reset values
`define ASENV_FLAGS_RESET 64'h0000_0000_0000_0002
`define ASENV_FLAGS_FIXED1 64'h0000_0000_0000_0002
`endif

//--- hw/asenv_xlate.v
// Linear-to-physical address translation for all memory models.
// Assumes a page frame from an external walker; purely combinational here.
`timescale 1ns/1ps
`default_nettype none
`include "asenv_regs.vh"
module asenv_xlate (
  input wire [1:0] i_model,
  input wire i_paging_en,
  input wire i_large_page,
  input wire i_ext_phys,
  input wire [63:0] i_seg_base,
  input wire [63:0] i_offset,
  input wire [63:0] i_frame,
  output wire [63:0] o_linear,
  output wire o_canonical,
  output wire o_seg_fault,
  output wire [63:0] o_phys
);
  // =====================================================================
  // Linear address formation
  wire [63:0] lin_wide;
  wire [63:0] lin_seg;
  wire [63:0] lin_real;
  wire [63:0] lin_flat;
  wire [63:0] top_bits;
  reg [63:0] phys_raw;
  reg [63:0] phys_lim;
  assign lin_wide = i_seg_base + i_offset; // Base never truncated
  assign lin_seg = {32'h0000_0000, i_seg_base[31:0] + i_offset[31:0]}; // [R13]
  assign lin_flat = {32'h0000_0000, i_offset[31:0]}; // [R12]
  // Real mode: low 20 bits of the segment base plus 16-bit offset, 20-bit wrap
  assign lin_real = {44'h000_0000_0000,
    i_seg_base[19:0] + {4'h0, i_offset[15:0]}}; // [R14]
  assign o_linear = (i_model == `ASENV_MODEL_WIDE) ? lin_wide :
    (i_model == `ASENV_MODEL_SEG) ? lin_seg :
    (i_model == `ASENV_MODEL_REAL) ? lin_real : lin_flat;
  // Segment offset limit of 2^32 bytes, or 64 KBytes in real mode
  assign o_seg_fault = ((i_model == `ASENV_MODEL_SEG) && (i_offset[63:32] != 32'h0)) ||
    ((i_model == `ASENV_MODEL_REAL) && (i_offset[63:16] != 48'h0)); // [R13] [R14]
  // =====================================================================
  // Canonical check: bits 63 down to top implemented bit all equal
  assign top_bits = o_linear;
  assign o_canonical = (i_model != `ASENV_MODEL_WIDE) ||
    (&top_bits[63:`ASENV_LIN_W-1]) || ~(|top_bits[63:`ASENV_LIN_W-1]); // [R20] [R9]
  // =====================================================================
  // Paging off: identity; paging on: frame plus page offset
  always @* begin
    if (!i_paging_en) begin
      phys_raw = o_linear; // [R15]
    end else if (i_large_page && (i_model != `ASENV_MODEL_WIDE)) begin
      phys_raw = {i_frame[63:`ASENV_LARGE_PAGE_SHIFT],
        o_linear[`ASENV_LARGE_PAGE_SHIFT-1:0]}; // [R17]
    end else begin
      phys_raw = {i_frame[63:`ASENV_PAGE_SHIFT], o_linear[`ASENV_PAGE_SHIFT-1:0]}; // [R16]
    end
    // Wide mode takes the wide width whether paging is on or off
    if (i_model == `ASENV_MODEL_WIDE) begin
      phys_lim = {24'h00_0000, phys_raw[`ASENV_PHYS_W-1:0]}; // [R18] [R9]
    end else if (i_paging_en && i_ext_phys) begin
      phys_lim = {28'h000_0000, phys_raw[`ASENV_LEGACY_PHYS_W-1:0]}; // [R17] [R11]
    end else begin
      phys_lim = {32'h0000_0000, phys_raw[31:0]};
    end
  end
  assign o_phys = phys_lim;
endmodule
`default_nettype wire

//--- hw/asenv_core.v
// Wide-mode architectural register environment and address-space front end.
// Assumes a decode stage drives one request per cycle; same clock throughout.
//
// Function
// [R1] Sixteen 64-bit general registers, four sizes
// [R2] Byte access uses low eight bits
// [R3] Instruction pointer is 64 bits wide
// [R4] Flags 64 bits, upper half reserved
// [R5] Stack pointer always 64 bits
// [R6] 64-bit control registers plus priority register
// [R7] Debug registers are 64 bits wide
// [R8] Descriptor table bases hold full 64 bits
// [R9] 2^64 linear, 2^40 physical, width reported
// [R10] Physical memory addressed per 8-bit byte
// [R11] Legacy physical limit is 2^36 minus one
// [R12] Flat model spans 0 to 2^32-1
// [R13] Segments translate selector plus offset
// [R14] Real mode 64K segments, 2^20 space
// [R15] Paging off maps linear straight through
// [R16] Paging on maps pages to frames
// [R17] Large pages and extended physical reach
// [R18] Wide mode uses extended paging widths
// [R19] Sixteen vector data registers
// [R20] Canonical check of top linear bits
// [R21] Reported width matches driven width
`timescale 1ns/1ps
`default_nettype none
`include "asenv_regs.vh"
module asenv_core (
  input wire i_sys_clk,
  input wire i_rst,
  // GPR write port
  input wire i_gpr_we,
  input wire [3:0] i_gpr_widx,
  input wire [1:0] i_gpr_wsize,
  input wire [63:0] i_gpr_wdata,
  // GPR read port
  input wire [3:0] i_gpr_ridx,
  input wire [1:0] i_gpr_rsize,
  output reg [63:0] o_gpr_rdata,
  // Instruction pointer
  input wire i_ip_we,
  input wire [63:0] i_ip_wdata,
  output reg [63:0] o_ip,
  // Flags
  input wire i_flags_we,
  input wire [63:0] i_flags_wdata,
  output reg [63:0] o_flags,
  // Stack pointer
  input wire i_sp_we,
  input wire [63:0] i_sp_wdata,
  output reg [63:0] o_sp,
  // Control and debug register port
  input wire i_sys_we,
  input wire i_sys_sel_dbg,
  input wire [3:0] i_sys_idx,
  input wire [63:0] i_sys_wdata,
  output reg [63:0] o_sys_rdata,
  output reg [3:0] o_task_priority,
  // Descriptor table and task registers
  input wire i_tbl_we,
  input wire [1:0] i_tbl_sel,
  input wire [63:0] i_tbl_base,
  input wire [15:0] i_tbl_limit,
  output reg [79:0] o_tbl_rdata,
  // Vector registers
  input wire i_vec_we,
  input wire [3:0] i_vec_widx,
  input wire [127:0] i_vec_wdata,
  input wire [3:0] i_vec_ridx,
  output reg [127:0] o_vec_rdata,
  // Address path
  input wire [1:0] i_model,
  input wire i_paging_en,
  input wire i_large_page,
  input wire i_ext_phys,
  input wire [63:0] i_seg_base,
  input wire [63:0] i_offset,
  input wire [63:0] i_frame,
  output reg [63:0] o_linear,
  output reg [63:0] o_phys,
  output reg o_canon_fault,
  output reg o_seg_fault,
  output reg [7:0] o_phys_width,
  output reg [7:0] o_lin_width
);
  // =====================================================================
  // Storage arrays
  reg [63:0] gpr_r [0:`ASENV_GPR_COUNT-1];
  reg [127:0] vec_r [0:`ASENV_VEC_COUNT-1];
  reg [63:0] ctrl_r [0:`ASENV_CTRL_COUNT-1];
  reg [63:0] dbg_r [0:`ASENV_DBG_COUNT-1];
  reg [79:0] tbl_r [0:3];
  reg [63:0] gpr_wr_nxt;
  reg [63:0] gpr_rd_nxt;
  reg [63:0] gpr_old;
  reg [63:0] gpr_cur;
  wire [63:0] lin_w;
  wire [63:0] phys_w;
  wire canon_w;
  wire seg_fault_w;
  // Width constants are 32-bit; the report ports take the low byte on purpose
  wire [31:0] phys_width_full = `ASENV_PHYS_W;
  wire [31:0] lin_width_full = `ASENV_LIN_W;
  integer i;

  // =====================================================================
  // GPR write merge: narrow writes replace low bits, dword zero-extends
  always @* begin
    gpr_old = gpr_r[i_gpr_widx];
    case (i_gpr_wsize)
      `ASENV_SZ_BYTE: gpr_wr_nxt = {gpr_old[63:8], i_gpr_wdata[7:0]}; // [R2]
      `ASENV_SZ_WORD: gpr_wr_nxt = {gpr_old[63:16], i_gpr_wdata[15:0]}; // [R1]
      `ASENV_SZ_DWORD: gpr_wr_nxt = {32'h0000_0000, i_gpr_wdata[31:0]}; // [R1]
      default: gpr_wr_nxt = i_gpr_wdata; // [R1]
    endcase
  end

  // GPR read sizing, the same low-byte view for all sixteen registers
  always @* begin
    gpr_cur = gpr_r[i_gpr_ridx];
    case (i_gpr_rsize)
      `ASENV_SZ_BYTE: gpr_rd_nxt = {56'h0, gpr_cur[7:0]}; // [R2]
      `ASENV_SZ_WORD: gpr_rd_nxt = {48'h0, gpr_cur[15:0]};
      `ASENV_SZ_DWORD: gpr_rd_nxt = {32'h0, gpr_cur[31:0]};
      default: gpr_rd_nxt = gpr_cur;
    endcase
  end

  // =====================================================================
  // General-purpose and vector registers
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (i = 0; i < `ASENV_GPR_COUNT; i = i + 1) begin
        gpr_r[i] <= 64'h0; // [R1]
        vec_r[i] <= 128'h0; // [R19]
      end
    end else begin
      if (i_gpr_we) begin
        gpr_r[i_gpr_widx] <= gpr_wr_nxt; // [R1]
      end
      if (i_vec_we) begin
        vec_r[i_vec_widx] <= i_vec_wdata; // [R19]
      end
    end
  end

  // =====================================================================
  // Instruction pointer, flags and stack pointer
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_ip <= 64'h0;
      o_flags <= `ASENV_FLAGS_RESET;
      o_sp <= 64'h0;
    end else begin
      if (i_ip_we) begin
        o_ip <= i_ip_wdata; // [R3]
      end
      // Reserved upper half kept zero so software never sees stale bits
      if (i_flags_we) begin
        o_flags <= {32'h0000_0000, i_flags_wdata[31:0]} | `ASENV_FLAGS_FIXED1; // [R4]
      end
      // No size input exists: the pointer is always written whole
      if (i_sp_we) begin
        o_sp <= i_sp_wdata; // [R5]
      end
    end
  end

  // =====================================================================
  // Control and debug registers; index 8 of control is the priority
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (i = 0; i < `ASENV_CTRL_COUNT; i = i + 1) begin
        ctrl_r[i] <= 64'h0;
      end
      for (i = 0; i < `ASENV_DBG_COUNT; i = i + 1) begin
        dbg_r[i] <= 64'h0;
      end
      o_task_priority <= 4'h0;
    end else if (i_sys_we) begin
      if (i_sys_sel_dbg) begin
        dbg_r[i_sys_idx[2:0]] <= i_sys_wdata; // [R7]
      end else if (i_sys_idx == 4'h8) begin
        ctrl_r[8] <= {60'h0, i_sys_wdata[3:0]}; // [R6]
        o_task_priority <= i_sys_wdata[3:0]; // [R6]
      end else begin
        ctrl_r[i_sys_idx] <= i_sys_wdata; // [R6]
      end
    end
  end

  // Registered read of the system port
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_sys_rdata <= 64'h0;
    end else if (i_sys_sel_dbg) begin
      o_sys_rdata <= dbg_r[i_sys_idx[2:0]]; // [R7]
    end else begin
      o_sys_rdata <= ctrl_r[i_sys_idx]; // [R6]
    end
  end

  // =====================================================================
  // Descriptor table registers: {limit, base}, 10 bytes each
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        tbl_r[i] <= 80'h0;
      end
      o_tbl_rdata <= 80'h0;
    end else begin
      if (i_tbl_we) begin
        tbl_r[i_tbl_sel] <= {i_tbl_limit, i_tbl_base}; // [R8]
      end
      o_tbl_rdata <= tbl_r[i_tbl_sel]; // [R8]
    end
  end

  // =====================================================================
  // Register read ports, one cycle latency
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_gpr_rdata <= 64'h0;
      o_vec_rdata <= 128'h0;
    end else begin
      o_gpr_rdata <= gpr_rd_nxt; // [R2]
      o_vec_rdata <= vec_r[i_vec_ridx]; // [R19]
    end
  end

  // =====================================================================
  // Address translation, registered for timing
  asenv_xlate u_xlate (
    .i_model(i_model),
    .i_paging_en(i_paging_en),
    .i_large_page(i_large_page),
    .i_ext_phys(i_ext_phys),
    .i_seg_base(i_seg_base),
    .i_offset(i_offset),
    .i_frame(i_frame),
    .o_linear(lin_w),
    .o_canonical(canon_w),
    .o_seg_fault(seg_fault_w),
    .o_phys(phys_w)
  );

  // Byte-granular physical address out; width report comes from same constant
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_linear <= 64'h0;
      o_phys <= 64'h0;
      o_canon_fault <= 1'b0;
      o_seg_fault <= 1'b0;
      o_phys_width <= 8'h0;
      o_lin_width <= 8'h0;
    end else begin
      o_linear <= lin_w; // [R9]
      o_phys <= phys_w; // [R10] [R15] [R16]
      o_canon_fault <= ~canon_w; // [R20]
      o_seg_fault <= seg_fault_w; // [R13]
      o_phys_width <= phys_width_full[7:0]; // [R21] [R9]
      o_lin_width <= lin_width_full[7:0]; // [R21]
    end
  end
endmodule
`default_nettype wire

//--- testbench/asenv_core_assertions.sv
// Port-level checker for the register environment core.
// Assumes it is bound to asenv_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
// ====================
// Checker
module asenv_core_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ip_we,
  input wire logic [63:0] i_ip_wdata,
  input wire logic [63:0] o_ip,
  input wire logic i_sp_we,
  input wire logic [63:0] i_sp_wdata,
  input wire logic [63:0] o_sp,
  input wire logic i_flags_we,
  input wire logic [63:0] i_flags_wdata,
  input wire logic [63:0] o_flags,
  input wire logic i_sys_we,
  input wire logic i_sys_sel_dbg,
  input wire logic [3:0] i_sys_idx,
  input wire logic [63:0] i_sys_wdata,
  input wire logic [3:0] o_task_priority,
  input wire logic [1:0] i_model,
  input wire logic i_paging_en,
  input wire logic [63:0] i_frame,
  input wire logic [63:0] o_linear,
  input wire logic [63:0] o_phys,
  input wire logic o_canon_fault,
  input wire logic [7:0] o_phys_width,
  input wire logic [7:0] o_lin_width
);
  // One clock domain; the first edge after reset still sees reset in $past
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  ip_write_hold_a: assert property (
    !$past(i_rst) |-> o_ip == ($past(i_ip_we) ? $past(i_ip_wdata) : $past(o_ip)))
    else $error("instruction pointer not written or not held");
  sp_write_hold_a: assert property (
    !$past(i_rst) |-> o_sp == ($past(i_sp_we) ? $past(i_sp_wdata) : $past(o_sp)))
    else $error("stack pointer not written or not held");
  flags_format_a: assert property (
    $past(i_flags_we) && !$past(i_rst) |->
    o_flags == (($past(i_flags_wdata) & 64'hffffffff) | 64'h2))
    else $error("flags write format wrong");
  priority_write_a: assert property (
    $past(i_sys_we) && !$past(i_sys_sel_dbg) && $past(i_sys_idx) == 4'h8 && !$past(i_rst)
    |-> {60'h0, o_task_priority} == ($past(i_sys_wdata) & 64'hf))
    else $error("task priority not updated");
  width_report_a: assert property (
    !$past(i_rst) |-> o_phys_width == 8'h28 && o_lin_width == 8'h30)
    else $error("reported widths wrong");
  canon_check_a: assert property (
    $past(i_model) == 2'h3 && !$past(i_rst) |->
    o_canon_fault == !(&o_linear[63:47] || ~|o_linear[63:47]))
    else $error("canonical check wrong");
  direct_map_a: assert property (
    $past(i_model) == 2'h3 && !$past(i_paging_en) && !$past(i_rst) |->
    o_phys == {24'h0, o_linear[39:0]})
    else $error("unpaged address translated");
  page_map_a: assert property (
    $past(i_model) == 2'h3 && $past(i_paging_en) && !$past(i_rst) |->
    o_phys == (($past(i_frame) & 64'hfffffff000) | (o_linear & 64'hfff)))
    else $error("paged address wrong");
endmodule
bind asenv_core asenv_core_checker u_chk (.i_sys_clk, .i_rst, .i_ip_we, .i_ip_wdata, .o_ip,
  .i_sp_we, .i_sp_wdata, .o_sp, .i_flags_we, .i_flags_wdata, .o_flags, .i_sys_we,
  .i_sys_sel_dbg, .i_sys_idx, .i_sys_wdata, .o_task_priority, .i_model, .i_paging_en,
  .i_frame, .o_linear, .o_phys, .o_canon_fault, .o_phys_width, .o_lin_width);
`default_nettype wire

//--- testbench/asenv_core_tb.sv
// Self-checking bench for the register environment core.
// Assumes the core is compiled first; one 100 MHz clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module asenv_core_tb;
  // ====================
  // Design signals, every input valued at time zero
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_gpr_we = 1'b0, i_ip_we = 1'b0, i_flags_we = 1'b0, i_sp_we = 1'b0, i_sys_we = 1'b0;
  logic i_sys_sel_dbg = 1'b0, i_tbl_we = 1'b0, i_vec_we = 1'b0, i_paging_en = 1'b0;
  logic i_large_page = 1'b0, i_ext_phys = 1'b0;
  logic [1:0] i_gpr_wsize = 2'h0, i_gpr_rsize = 2'h0, i_tbl_sel = 2'h0, i_model = 2'h0;
  logic [3:0] i_gpr_widx = 4'h0, i_gpr_ridx = 4'h0, i_sys_idx = 4'h0;
  logic [3:0] i_vec_widx = 4'h0, i_vec_ridx = 4'h0;
  logic [15:0] i_tbl_limit = 16'h0;
  logic [63:0] i_gpr_wdata = 64'h0, i_ip_wdata = 64'h0, i_flags_wdata = 64'h0;
  logic [63:0] i_sp_wdata = 64'h0, i_sys_wdata = 64'h0, i_tbl_base = 64'h0;
  logic [63:0] i_seg_base = 64'h0, i_offset = 64'h0, i_frame = 64'h0;
  logic [127:0] i_vec_wdata = 128'h0;
  logic [63:0] o_gpr_rdata, o_ip, o_flags, o_sp, o_sys_rdata, o_linear, o_phys;
  logic [79:0] o_tbl_rdata;
  logic [127:0] o_vec_rdata;
  logic [7:0] o_phys_width, o_lin_width;
  logic [3:0] o_task_priority;
  logic o_canon_fault, o_seg_fault;
  int error_cnt = 0;
  int total_checks = 0;
  asenv_core dut (.i_sys_clk, .i_rst, .i_gpr_we, .i_gpr_widx, .i_gpr_wsize, .i_gpr_wdata,
    .i_gpr_ridx, .i_gpr_rsize, .o_gpr_rdata, .i_ip_we, .i_ip_wdata, .o_ip, .i_flags_we,
    .i_flags_wdata, .o_flags, .i_sp_we, .i_sp_wdata, .o_sp, .i_sys_we, .i_sys_sel_dbg,
    .i_sys_idx, .i_sys_wdata, .o_sys_rdata, .o_task_priority, .i_tbl_we, .i_tbl_sel,
    .i_tbl_base, .i_tbl_limit, .o_tbl_rdata, .i_vec_we, .i_vec_widx, .i_vec_wdata,
    .i_vec_ridx, .o_vec_rdata, .i_model, .i_paging_en, .i_large_page, .i_ext_phys,
    .i_seg_base, .i_offset, .i_frame, .o_linear, .o_phys, .o_canon_fault, .o_seg_fault,
    .o_phys_width, .o_lin_width);
  // 100 MHz clock
  always #5 i_sys_clk = ~i_sys_clk;
  // ====================
  // Shared tasks; outputs are looked at 1 ns after the edge so they have settled
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic settle;
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic gpr_wr(input logic [3:0] idx, input logic [1:0] sz, input logic [63:0] d);
    @(posedge i_sys_clk);
    i_gpr_we <= 1'b1;
    i_gpr_widx <= idx;
    i_gpr_wsize <= sz;
    i_gpr_wdata <= d;
    @(posedge i_sys_clk);
    i_gpr_we <= 1'b0;
  endtask
  task automatic gpr_chk(input logic [3:0] idx, input logic [1:0] sz, input logic [63:0] e);
    @(posedge i_sys_clk);
    i_gpr_ridx <= idx;
    i_gpr_rsize <= sz;
    settle();
    chk(o_gpr_rdata, e);
  endtask
  // Write one control or debug register, then leave the read selected on it
  task automatic sys_wr(input logic dbg, input logic [3:0] idx, input logic [63:0] d);
    @(posedge i_sys_clk);
    i_sys_we <= 1'b1;
    i_sys_sel_dbg <= dbg;
    i_sys_idx <= idx;
    i_sys_wdata <= d;
    @(posedge i_sys_clk);
    i_sys_we <= 1'b0;
    settle();
  endtask
  // cfg is {model, paging, large page, extended physical}; flt is {canonical, segment}
  task automatic adr(input logic [4:0] cfg, input logic [63:0] aux, input logic [63:0] ofs,
                     input logic [63:0] lin, input logic [63:0] ph, input logic [1:0] flt);
    @(posedge i_sys_clk);
    {i_model, i_paging_en, i_large_page, i_ext_phys} <= cfg;
    i_seg_base <= cfg[2] ? 64'h0 : aux;
    i_frame <= cfg[2] ? aux : ~aux;
    i_offset <= ofs;
    settle();
    chk(o_linear, lin);
    chk(o_phys, ph);
    chk({o_canon_fault, o_seg_fault}, flt);
  endtask
  // ====================
  // Scenarios
  task automatic t_reset;
    chk(o_flags, 64'h2);
    chk({o_ip, o_sp}, 128'h0);
    chk({o_phys_width, o_lin_width}, 16'h2830);
    $display("test reset done");
  endtask
  task automatic t_gpr;
    gpr_wr(4'h3, 2'h3, 64'h0123456789abcdef);
    gpr_wr(4'h3, 2'h0, 64'hffffffffffffff5a);
    gpr_chk(4'h3, 2'h0, 64'h5a);
    gpr_chk(4'h3, 2'h1, 64'hcd5a);
    gpr_chk(4'h3, 2'h2, 64'h89abcd5a);
    gpr_chk(4'h3, 2'h3, 64'h0123456789abcd5a);
    gpr_wr(4'hf, 2'h2, 64'hffffffff11223344);
    gpr_wr(4'hf, 2'h1, 64'hffffffffffff9988);
    gpr_chk(4'hf, 2'h3, 64'h11229988);
    $display("test gpr done");
  endtask
  task automatic t_ptr;
    @(posedge i_sys_clk);
    i_ip_we <= 1'b1;
    i_ip_wdata <= 64'hfedcba9876543210;
    i_sp_we <= 1'b1;
    i_sp_wdata <= 64'h8000000000000008;
    i_flags_we <= 1'b1;
    i_flags_wdata <= 64'hffffffff00000ad5;
    @(posedge i_sys_clk);
    {i_ip_we, i_sp_we, i_flags_we} <= 3'h0;
    settle();
    chk(o_ip, 64'hfedcba9876543210);
    chk(o_sp, 64'h8000000000000008);
    chk(o_flags, 64'h0ad7);
    $display("test pointers done");
  endtask
  task automatic t_sys;
    sys_wr(1'b0, 4'h8, 64'hfffffffffffffffa);
    chk({o_task_priority, o_sys_rdata}, {4'ha, 64'ha});
    sys_wr(1'b0, 4'h3, 64'hdeadbeefcafef00d);
    chk(o_sys_rdata, 64'hdeadbeefcafef00d);
    sys_wr(1'b1, 4'hf, 64'h8000000000000001);
    chk({o_task_priority, o_sys_rdata}, {4'ha, 64'h8000000000000001});
    $display("test system registers done");
  endtask
  // Back-to-back writes of all four tables, then each read back whole
  task automatic t_tbl;
    for (int s = 0; s < 4; s++) begin
      @(posedge i_sys_clk);
      i_tbl_we <= 1'b1;
      i_tbl_sel <= s[1:0];
      i_tbl_base <= 64'hf000000000000000 + 64'(s);
      i_tbl_limit <= 16'h0100 + 16'(s);
    end
    @(posedge i_sys_clk);
    i_tbl_we <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      i_tbl_sel <= s[1:0];
      settle();
      chk(o_tbl_rdata, {16'h0100 + 16'(s), 64'hf000000000000000 + 64'(s)});
      @(posedge i_sys_clk);
    end
    $display("test tables done");
  endtask
  task automatic t_vec;
    @(posedge i_sys_clk);
    i_vec_we <= 1'b1;
    i_vec_widx <= 4'hf;
    i_vec_wdata <= {2{64'hc3c3c3c3c3c3c3c3}};
    @(posedge i_sys_clk);
    i_vec_widx <= 4'h0;
    i_vec_wdata <= {2{64'h1}};
    @(posedge i_sys_clk);
    i_vec_we <= 1'b0;
    i_vec_ridx <= 4'hf;
    settle();
    chk(o_vec_rdata, {2{64'hc3c3c3c3c3c3c3c3}});
    @(posedge i_sys_clk);
    i_vec_ridx <= 4'h0;
    settle();
    chk(o_vec_rdata, {2{64'h1}});
    $display("test vectors done");
  endtask
  task automatic t_addr;
    adr(5'h18, 64'h0, 64'hffff800000001234, 64'hffff800000001234, 64'h1234, 2'h0);
    adr(5'h18, 64'h0, 64'h800000000000, 64'h800000000000, 64'h0, 2'h2);
    adr(5'h1c, 64'haabbccd000, 64'h401abc, 64'h401abc, 64'haabbccdabc, 2'h0);
    adr(5'h1e, 64'haabbccd000, 64'h401abc, 64'h401abc, 64'haabbccdabc, 2'h0);
    adr(5'h00, 64'h5555, 64'h123456789abcdef0, 64'h9abcdef0, 64'h9abcdef0, 2'h0);
    adr(5'h08, 64'h1000, 64'h234, 64'h1234, 64'h1234, 2'h0);
    adr(5'h08, 64'h1000, 64'h100000000, 64'h1000, 64'h1000, 2'h1);
    adr(5'h10, 64'hffff0, 64'h20, 64'h10, 64'h10, 2'h0);
    adr(5'h07, 64'hfffc00000, 64'h1234567, 64'h1234567, 64'hfffe34567, 2'h0);
    $display("test address paths done");
  endtask
  // Reset again in mid-run: state returns to its reset values, widths come back
  task automatic t_rerst;
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    @(posedge i_sys_clk);
    i_rst <= 1'b0;
    #1;
    chk({o_ip, o_sp}, 128'h0);
    chk(o_flags, 64'h2);
    chk({o_phys_width, o_lin_width}, 16'h0);
    settle();
    chk({o_phys_width, o_lin_width}, 16'h2830);
    $display("test second reset done");
  endtask
  // ====================
  // Main sequence and hang guard
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    settle();
    t_reset();
    t_gpr();
    t_ptr();
    t_sys();
    t_tbl();
    t_vec();
    t_addr();
    t_rerst();
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    error_cnt++;
    $display("MISMATCH t=%0t run did not finish", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
